// >>> rtl/plsr_consts.svh
// constants of the pll status readback block: offsets, fields, reset values
`ifndef PLSR_CONSTS_SVH
`define PLSR_CONSTS_SVH

// ==============================================================
// register indices (byte address is four times the index)
`define PLSR_IDX_REF_THRESH 8'h1a
`define PLSR_IDX_HOLD_CTRL 8'h1d
`define PLSR_IDX_STATUS 8'h1f
`define PLSR_IDX_IRQ_STATUS 8'h20
`define PLSR_IDX_IRQ_MASK 8'h21

// ==============================================================
// field positions
`define PLSR_BIT_THRESH_SEL 6
`define PLSR_BIT_READBACK_DIS 4
`define PLSR_BIT_HOLD_EN_B 2
`define PLSR_BIT_EXT_HOLD 1
`define PLSR_BIT_HOLD_EN_A 0
`define PLSR_HOLD_CTRL_MASK 8'h17
`define PLSR_REF_THRESH_MASK 8'h40

// ==============================================================
// reset values
`define PLSR_RST_REF_THRESH 8'h00
`define PLSR_RST_HOLD_CTRL 8'h00
`define PLSR_RST_IRQ_MASK 7'h00

// ==============================================================
// widths
`define PLSR_STATUS_W 7

`endif

// >>> rtl/plsr_pkg.sv
// types shared by the pll status readback block
package plsr_pkg;

	// ==============================================================
	// live status conditions, packed in register bit order 6..0
	typedef struct packed {
		logic vco_cal_done;
		logic holdover_active;
		logic secondary_selected;
		logic vco_above_thresh;
		logic secondary_above_thresh;
		logic primary_above_thresh;
		logic pll_locked;
	} plsr_status_t;

	// ==============================================================
	// holdover control towards the holdover controller
	typedef struct packed {
		logic auto_enable;
		logic ext_pin_enable;
	} plsr_hold_ctrl_t;

endpackage : plsr_pkg

// >>> rtl/plsr_sync.sv
// three-stage pin synchroniser; output moves once stages two and three agree
`timescale 1ns/100ps
module plsr_sync #(
	parameter int WIDTH = 7
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// asynchronous input and filtered result
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_sync_out;

	always_comb begin
		next_sync_out = sync_out;
		for (int i = 0; i < WIDTH; i++) begin
			if (stage2[i] == stage3[i]) begin
				next_sync_out[i] = stage3[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			sync_out <= next_sync_out;
		end
	end

endmodule : plsr_sync

// >>> rtl/plsr_irq.sv
// sticky event flags with write-one-to-clear, mask and one level interrupt
`timescale 1ns/100ps
module plsr_irq
	import plsr_pkg::*;
#(
	parameter int WIDTH = 7
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// events and software access
	input wire logic [WIDTH-1:0] event_set,
	input wire logic [WIDTH-1:0] clear_ones,
	input wire logic mask_we,
	input wire logic [WIDTH-1:0] mask_wdata,
	// state
	output logic [WIDTH-1:0] flags,
	output logic [WIDTH-1:0] mask,
	output logic irq
);

	`include "plsr_consts.svh"

	logic [WIDTH-1:0] next_flags;
	logic [WIDTH-1:0] next_mask;

	always_comb begin
		// a set in the clearing cycle must survive
		next_flags = (flags & ~clear_ones) | event_set;
		next_mask = mask_we ? mask_wdata : mask;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= '0;
			mask <= WIDTH'(`PLSR_RST_IRQ_MASK);
		end else begin
			flags <= next_flags;
			mask <= next_mask;
		end
	end

	assign irq = |(flags & mask);

endmodule : plsr_irq

// >>> rtl/plsr_top.sv
// pll status readback register bank with holdover control, on an apb slave
`timescale 1ns/100ps
module plsr_top
	import plsr_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// live conditions from the pll core
	input wire plsr_status_t pll_conditions,
	// controls to the pll core
	output plsr_hold_ctrl_t hold_ctrl,
	output logic thresh_select,
	// interrupt
	output logic irq
);

	`include "plsr_consts.svh"

	localparam int SW = `PLSR_STATUS_W;

	// ==============================================================
	// address decode
	function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
		reg_addr = ADDR_W'({idx, 2'b00});
	endfunction : reg_addr

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		hit = (a == reg_addr(idx));
	endfunction : hit

	// ==============================================================
	// synchronised live status
	plsr_status_t status_live;
	logic [SW-1:0] status_bits;
	logic [SW-1:0] status_prev;
	logic [SW-1:0] next_status_prev;

	// the conditions come from other clocks in the pll core
	plsr_sync #(
		.WIDTH(SW)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(pll_conditions),
		.sync_out(status_bits)
	);

	assign status_live = plsr_status_t'(status_bits);

	// ==============================================================
	// control registers
	logic [7:0] ref_thresh;
	logic [7:0] hold_cfg;
	logic [7:0] next_ref_thresh;
	logic [7:0] next_hold_cfg;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic wr_access;
	logic setup;
	logic mapped;
	logic [SW-1:0] irq_clear;
	logic irq_mask_we;
	logic [SW-1:0] irq_flags;
	logic [SW-1:0] irq_mask;
	logic [SW-1:0] status_view;

	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign setup = psel && !penable;
	assign wr_access = psel && penable && pwrite;

	always_comb begin
		mapped = hit(paddr, `PLSR_IDX_REF_THRESH) || hit(paddr, `PLSR_IDX_HOLD_CTRL)
			|| hit(paddr, `PLSR_IDX_STATUS) || hit(paddr, `PLSR_IDX_IRQ_STATUS)
			|| hit(paddr, `PLSR_IDX_IRQ_MASK);
	end

	// status writes fall through with no effect
	always_comb begin
		next_ref_thresh = ref_thresh;
		next_hold_cfg = hold_cfg;
		irq_clear = '0;
		irq_mask_we = 1'b0;
		if (wr_access) begin
			if (hit(paddr, `PLSR_IDX_REF_THRESH)) begin
				next_ref_thresh = pwdata[7:0] & `PLSR_REF_THRESH_MASK;
			end
			if (hit(paddr, `PLSR_IDX_HOLD_CTRL)) begin
				next_hold_cfg = pwdata[7:0] & `PLSR_HOLD_CTRL_MASK;
			end
			if (hit(paddr, `PLSR_IDX_IRQ_STATUS)) begin
				irq_clear = pwdata[SW-1:0];
			end
			if (hit(paddr, `PLSR_IDX_IRQ_MASK)) begin
				irq_mask_we = 1'b1;
			end
		end
	end

	// ==============================================================
	// readback
	always_comb begin
		// disabled readback returns zero rather than stale state
		if (hold_cfg[`PLSR_BIT_READBACK_DIS]) begin
			status_view = '0;
		end else begin
			status_view = status_bits;
		end
	end

	always_comb begin
		next_prdata = prdata;
		next_pslverr = 1'b0;
		if (setup) begin
			next_prdata = '0;
			next_pslverr = !mapped;
			if (!pwrite) begin
				if (hit(paddr, `PLSR_IDX_REF_THRESH)) begin
					next_prdata = {24'h000000, ref_thresh};
				end else if (hit(paddr, `PLSR_IDX_HOLD_CTRL)) begin
					next_prdata = {24'h000000, hold_cfg};
				end else if (hit(paddr, `PLSR_IDX_STATUS)) begin
					next_prdata = {25'h0000000, status_view};
				end else if (hit(paddr, `PLSR_IDX_IRQ_STATUS)) begin
					next_prdata = {25'h0000000, irq_flags};
				end else if (hit(paddr, `PLSR_IDX_IRQ_MASK)) begin
					next_prdata = {25'h0000000, irq_mask};
				end
			end
		end else if (!psel) begin
			next_prdata = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_thresh <= `PLSR_RST_REF_THRESH;
			hold_cfg <= `PLSR_RST_HOLD_CTRL;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			ref_thresh <= next_ref_thresh;
			hold_cfg <= next_hold_cfg;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// ==============================================================
	// holdover control and threshold select
	logic hold_enabled;

	assign hold_enabled = hold_cfg[`PLSR_BIT_HOLD_EN_A] && hold_cfg[`PLSR_BIT_HOLD_EN_B];

	always_comb begin
		hold_ctrl.auto_enable = hold_enabled && !hold_cfg[`PLSR_BIT_EXT_HOLD];
		hold_ctrl.ext_pin_enable = hold_enabled && hold_cfg[`PLSR_BIT_EXT_HOLD];
	end

	// selects which reference threshold the monitor compares against
	assign thresh_select = ref_thresh[`PLSR_BIT_THRESH_SEL];

	// ==============================================================
	// change events: any edge of a status bit raises its flag
	always_comb begin
		next_status_prev = status_bits;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_prev <= '0;
		end else begin
			status_prev <= next_status_prev;
		end
	end

	plsr_irq #(
		.WIDTH(SW)
	) u_irq (
		.pclk(pclk),
		.presetn(presetn),
		.event_set(status_bits ^ status_prev),
		.clear_ones(irq_clear),
		.mask_we(irq_mask_we),
		.mask_wdata(pwdata[SW-1:0]),
		.flags(irq_flags),
		.mask(irq_mask),
		.irq(irq)
	);

endmodule : plsr_top

// >>> verification/plsr_checker.sv
// concurrent checks on the pll status register bank ports
`timescale 1ns/100ps
module plsr_checker
	import plsr_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// core side
	input wire plsr_status_t pll_conditions,
	input wire plsr_hold_ctrl_t hold_ctrl,
	input wire logic thresh_select,
	input wire logic irq
);
	// ==========
	// helpers
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc, stat_rd, dis, next_dis, auto_w, ext_w, thr_w;
	assign acc = psel && penable;
	assign stat_rd = acc && !pwrite && paddr == 8'h7c;
	assign auto_w = pwdata[0] & pwdata[2] & ~pwdata[1];
	assign ext_w = pwdata[0] & pwdata[2] & pwdata[1];
	assign thr_w = pwdata[6];
	// shadow of the readback-disable bit, not visible at the ports
	always_comb begin
		next_dis = dis;
		if (acc && pwrite && paddr == 8'h74) begin
			next_dis = pwdata[4];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dis <= 1'b0;
		end else begin
			dis <= next_dis;
		end
	end
	// ==========
	// assertions
	sequence s_steady;
		$stable(pll_conditions) [*8];
	endsequence
	a_ready_const: assert property (pready) else $error("pready low");
	a_hold_map: assert property (acc && pwrite && paddr == 8'h74 |=>
		hold_ctrl == {$past(auto_w), $past(ext_w)}) else $error("hold_ctrl wrong");
	a_thresh_map: assert property (acc && pwrite && paddr == 8'h68 |=>
		thresh_select == $past(thr_w)) else $error("thresh_select wrong");
	a_status_live: assert property (s_steady ##0 (stat_rd && !dis) |->
		prdata == {25'h0, pll_conditions}) else $error("status read wrong");
	a_blank_read: assert property (stat_rd && dis |-> prdata == 32'h0)
		else $error("blanked status not zero");
	a_status_ro: assert property (acc && pwrite && paddr == 8'h7c |-> !pslverr ##1
		$stable(hold_ctrl) && $stable(thresh_select)) else $error("status write took effect");
	a_unmapped_err: assert property (acc && !(paddr inside {8'h68, 8'h74, 8'h7c, 8'h80, 8'h84})
		|-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped not refused");
	a_mask_off: assert property (acc && pwrite && paddr == 8'h84 && pwdata[6:0] == 7'h0
		|=> !irq) else $error("irq with mask clear");
endmodule : plsr_checker

bind plsr_top plsr_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .pll_conditions(pll_conditions),
	.hold_ctrl(hold_ctrl), .thresh_select(thresh_select), .irq(irq));

// >>> verification/tb_top.sv
// self-checking bench for the pll status register bank
`timescale 1ns/100ps
module tb_top
	import plsr_pkg::*;
;
	// ==========
	// signals
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, thresh_select, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	plsr_status_t cond;
	plsr_hold_ctrl_t hold_ctrl;
	logic [32:0] notes[$];
	logic [32:0] e;
	logic [6:0] v;
	int bad_count = 0;
	int n_checks = 0;
	int cycles = 0;
	plsr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .pll_conditions(cond), .hold_ctrl(hold_ctrl),
		.thresh_select(thresh_select), .irq(irq));
	always #25 pclk = ~pclk;
	// ==========
	// tasks
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run
	// one idle edge at the end keeps back-to-back calls from double assigning psel
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (!pready) @(posedge pclk);
		psel <= 1'b0; penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] x, input logic err);
		notes.push_back({err, x});
		apb(1'b0, a, 32'h0);
	endtask : rd
	// ==========
	// monitor and timeout
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			e = notes.pop_front();
			chk("prdata", e[31:0], prdata);
			chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
		end
		cycles++;
		if (cycles == 4000) begin
			bad_count++;
			complete_run();
		end
	end
	// ==========
	// tests
	initial begin
		void'($urandom(66319));
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h0; pwdata = 32'h0; cond = '0; v = 7'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (10) @(posedge pclk);
		rd(8'h68, 32'h0, 1'b0);
		rd(8'h74, 32'h0, 1'b0);
		rd(8'h84, 32'h0, 1'b0);
		chk("hold_ctrl", 32'h0, {30'h0, hold_ctrl});
		$display("test reset done");
		for (int i = 0; i < 10; i++) begin
			v = (i < 7) ? 7'h1 << i : 7'($urandom);
			cond <= v;
			repeat (8) @(posedge pclk);
			rd(8'h7c, {25'h0, v}, 1'b0);
			apb(1'b1, 8'h7c, {25'h0, ~v});
			rd(8'h7c, {25'h0, v}, 1'b0);
		end
		apb(1'b1, 8'h74, 32'h10);
		rd(8'h7c, 32'h0, 1'b0);
		rd(8'h74, 32'h10, 1'b0);
		apb(1'b1, 8'h74, 32'h0);
		rd(8'h7c, {25'h0, v}, 1'b0);
		$display("test status done");
		// calibration reported finished before any holdover enable is written
		v = v | 7'h40;
		cond <= v;
		repeat (8) @(posedge pclk);
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, 8'h74, 32'hffffffe8 | k);
			chk("hold_ctrl", {30'h0, k[0] & k[2] & ~k[1], k[0] & k[2] & k[1]},
				{30'h0, hold_ctrl});
			rd(8'h74, 32'(k), 1'b0);
		end
		apb(1'b1, 8'h68, 32'hffffffff);
		chk("thresh_select", 32'h1, {31'h0, thresh_select});
		rd(8'h68, 32'h40, 1'b0);
		apb(1'b1, 8'h68, 32'h0);
		chk("thresh_select", 32'h0, {31'h0, thresh_select});
		$display("test control done");
		apb(1'b1, 8'h80, 32'h7f);
		rd(8'h80, 32'h0, 1'b0);
		apb(1'b1, 8'h84, 32'h7f);
		cond <= v ^ 7'h1;
		for (int n = 0; n < 10 && irq !== 1'b1; n++) @(posedge pclk);
		chk("irq", 32'h1, {31'h0, irq});
		rd(8'h80, 32'h1, 1'b0);
		apb(1'b1, 8'h84, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		apb(1'b1, 8'h80, 32'h1);
		apb(1'b1, 8'h84, 32'h7f);
		chk("irq", 32'h0, {31'h0, irq});
		rd(8'h84, 32'h7f, 1'b0);
		rd(8'h80, 32'h0, 1'b0);
		$display("test interrupt done");
		rd(8'h10, 32'h0, 1'b1);
		apb(1'b1, 8'h10, 32'hff);
		rd(8'h7c, {25'h0, v ^ 7'h1}, 1'b0);
		$display("test unmapped done");
		complete_run();
	end
endmodule : tb_top
